// ### core/gpio_map.svh
// Purpose: offsets, reset values and field positions of the port block
// Assumes: eight-bit registers on a plain register port
// Notes: included by the modules, not by the package
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
`define GPIO_ADDR_W 4
`define GPIO_OFF_PIN 4'h0
`define GPIO_OFF_LAT 4'h1
`define GPIO_OFF_DIR 4'h2
`define GPIO_OFF_ANA 4'h3
`define GPIO_OFF_PUP 4'h4
`define GPIO_OFF_THR 4'h5
`define GPIO_OFF_SLEW 4'h6
`define GPIO_OFF_ODR 4'h7
`define GPIO_OFF_I2C 4'h8
`define GPIO_OFF_RISE 4'h9
`define GPIO_OFF_FALL 4'ha
`define GPIO_OFF_FLAG 4'hb
`define GPIO_OFF_ROUTE 4'hc
`define GPIO_RST_DIR 8'hff
`define GPIO_RST_ANA 8'hff
`define GPIO_RST_ZERO 8'h00
`define GPIO_I2C_SLEW 0
`define GPIO_I2C_PULL 1
`define GPIO_I2C_SMB 2
`endif

// ### core/gpio_pkg.sv
// Purpose: shared types of the port block
// Assumes: nothing beyond the map header
// Notes: pin owner enumeration in priority order
package gpio_pkg;
  // owner of a pin after priority resolution
  typedef enum logic [1:0] {
    GPIO_OWN_CFG = 2'b00,
    GPIO_OWN_AOUT = 2'b01,
    GPIO_OWN_AIN = 2'b10,
    GPIO_OWN_PORT = 2'b11
  } gpio_owner_t;
endpackage : gpio_pkg

// ### core/gpio_edge.sv
// Purpose: per-pin rising and falling edge detection with sticky flags
// Assumes: pin input already qualified by input buffer enable
// Notes: set wins over software clear
`timescale 1ns/100ps
`include "gpio_map.svh"
module gpio_edge #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [W-1:0] pinIn,
  input wire logic [W-1:0] riseEn,
  input wire logic [W-1:0] fallEn,
  input wire logic [W-1:0] clrMask,
  output logic [W-1:0] flags
);
  logic [W-1:0] prev_q; // last sampled level
  logic [W-1:0] flag_q; // sticky change flags
  logic [W-1:0] hit; // edge this cycle

  // rising or falling edge per enable
  assign hit = (riseEn & pinIn & ~prev_q) | (fallEn & ~pinIn & prev_q);

  // history of the qualified pin level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_q <= '0;
    end else if (clkEn) begin
      prev_q <= pinIn;
    end
  end

  // sticky flags, new edge beats clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_q <= '0;
    end else if (clkEn) begin
      flag_q <= (flag_q & ~clrMask) | hit;
    end
  end

  assign flags = flag_q;
endmodule : gpio_edge

// ### core/gpio_port.sv
// Purpose: one eight-bit general purpose port with pad controls
// Assumes: pins synchronous to clk; register port with one-cycle read data
// Notes: pad drive fields leave as level outputs for the pad ring
//
// Operation
// - latch and pin writes hit same latch
// - latch reads stored, pin reads levels
// - analog select disables digital input
// - reset routes every pin to latch
// - analog output wins below config, driver goes tristate
// - priority: config, analog out, in, port
// - direction one input, zero drives latch
// - eight-bit bidirectional port, bit per pin
// - pin register write stores write data in latch
// - latch holds most recent write
// - direction still controls analog-input pins
// - analog-input pins read as zero
// - analog select leaves digital output alone
// - analog select resets to analog mode
// - open-drain bit makes output sink-only
// - slew bit selects limited slew
// - threshold bit selects schmitt or ttl
// - weak pull-up per pin
// - per-pin rising or falling change detect
// - enabled peripheral takes output, read stays
// - i2c pad: slew, pull-ups, smbus levels
`timescale 1ns/100ps
`include "gpio_map.svh"
module gpio_port
  import gpio_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [`GPIO_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [W-1:0] padIn,
  output logic [W-1:0] padOut,
  output logic [W-1:0] padOe,
  input wire logic [W-1:0] cfgOwn,
  input wire logic [W-1:0] cfgOut,
  input wire logic [W-1:0] cfgOe,
  input wire logic [W-1:0] anaOutEn,
  input wire logic [W-1:0] periphEn,
  input wire logic [W-1:0] periphOut,
  input wire logic [W-1:0] periphOe,
  output logic [W-1:0] periphIn,
  output logic [W-1:0] pullEn,
  output logic [W-1:0] slewLimit,
  output logic [W-1:0] ttlSel,
  output logic [W-1:0] i2cSlew,
  output logic [W-1:0] i2cPull,
  output logic [W-1:0] smbLevel,
  output logic [W-1:0] changeFlags
);
  logic [W-1:0] lat_q; // output latch, one bit per pin
  logic [W-1:0] dir_q; // direction, one is input
  logic [W-1:0] ana_q; // analog select
  logic [W-1:0] pup_q; // weak pull-up enables
  logic [W-1:0] thr_q; // threshold select, one is ttl
  logic [W-1:0] slew_q; // slew limit select
  logic [W-1:0] odr_q; // open-drain select
  logic [W-1:0] rise_q; // rising edge enables
  logic [W-1:0] fall_q; // falling edge enables
  logic [W-1:0] route_q; // one routes a peripheral
  logic [2:0] i2c_q [W]; // i2c pad control per pin
  logic [7:0] rdata_q; // read data register
  logic [W-1:0] digIn; // qualified digital input
  logic [W-1:0] srcOut; // selected output value
  logic [W-1:0] srcOe; // selected driver enable
  logic [W-1:0] clrMask; // flag clear strobe
  logic [W-1:0] flags; // edge flags
  gpio_owner_t owner [W]; // resolved pin owner

  // write strobe for one offset
  function automatic logic wrHit(input logic [`GPIO_ADDR_W-1:0] off);
    wrHit = regWr && (regAddr == off);
  endfunction : wrHit

  // zero-extend port data to bus width
  function automatic logic [7:0] ext(input logic [W-1:0] v);
    ext = 8'(v);
  endfunction : ext

  // digital buffer off in analog mode, so reads give zero
  assign digIn = padIn & ~ana_q;

  // output latch, either register writes it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lat_q <= `GPIO_RST_ZERO;
    end else if (clkEn) begin
      if (wrHit(`GPIO_OFF_PIN) || wrHit(`GPIO_OFF_LAT)) begin
        lat_q <= regWdata[W-1:0];
      end
    end
  end

  // direction and analog select, both reset to input/analog
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dir_q <= `GPIO_RST_DIR;
      ana_q <= `GPIO_RST_ANA;
    end else if (clkEn) begin
      if (wrHit(`GPIO_OFF_DIR)) begin
        dir_q <= regWdata[W-1:0];
      end
      if (wrHit(`GPIO_OFF_ANA)) begin
        ana_q <= regWdata[W-1:0];
      end
    end
  end

  // pad option registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pup_q <= `GPIO_RST_ZERO;
      thr_q <= `GPIO_RST_ZERO;
      slew_q <= `GPIO_RST_ZERO;
      odr_q <= `GPIO_RST_ZERO;
    end else if (clkEn) begin
      if (wrHit(`GPIO_OFF_PUP)) begin
        pup_q <= regWdata[W-1:0];
      end
      if (wrHit(`GPIO_OFF_THR)) begin
        thr_q <= regWdata[W-1:0];
      end
      if (wrHit(`GPIO_OFF_SLEW)) begin
        slew_q <= regWdata[W-1:0];
      end
      if (wrHit(`GPIO_OFF_ODR)) begin
        odr_q <= regWdata[W-1:0];
      end
    end
  end

  // change enables and routing selects
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rise_q <= `GPIO_RST_ZERO;
      fall_q <= `GPIO_RST_ZERO;
      route_q <= `GPIO_RST_ZERO;
    end else if (clkEn) begin
      if (wrHit(`GPIO_OFF_RISE)) begin
        rise_q <= regWdata[W-1:0];
      end
      if (wrHit(`GPIO_OFF_FALL)) begin
        fall_q <= regWdata[W-1:0];
      end
      if (wrHit(`GPIO_OFF_ROUTE)) begin
        route_q <= regWdata[W-1:0];
      end
    end
  end

  // i2c pad controls; write data bits 7:4 select the pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < W; i++) begin
        i2c_q[i] <= 3'h0;
      end
    end else if (clkEn) begin
      for (int i = 0; i < W; i++) begin
        if (wrHit(`GPIO_OFF_I2C) && (int'(regWdata[7:4]) == i)) begin
          i2c_q[i] <= regWdata[2:0];
        end
      end
    end
  end

  // pad option outputs
  always_comb begin
    for (int i = 0; i < W; i++) begin
      i2cSlew[i] = i2c_q[i][`GPIO_I2C_SLEW];
      i2cPull[i] = i2c_q[i][`GPIO_I2C_PULL];
      smbLevel[i] = i2c_q[i][`GPIO_I2C_SMB];
    end
  end
  assign pullEn = pup_q;
  assign slewLimit = slew_q;
  assign ttlSel = thr_q;
  // peripherals see the qualified pin, zero under analog select; i2c pads via smbus buffer upstream
  assign periphIn = digIn;

  // owner resolution in fixed priority order
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (cfgOwn[i]) begin
        owner[i] = GPIO_OWN_CFG;
      end else if (anaOutEn[i]) begin
        owner[i] = GPIO_OWN_AOUT;
      end else if (ana_q[i]) begin
        owner[i] = GPIO_OWN_AIN;
      end else begin
        owner[i] = GPIO_OWN_PORT;
      end
    end
  end

  // output source per owner
  always_comb begin
    for (int i = 0; i < W; i++) begin
      case (owner[i])
        GPIO_OWN_CFG: begin
          srcOut[i] = cfgOut[i];
          srcOe[i] = cfgOe[i];
        end
        GPIO_OWN_AOUT: begin
          srcOut[i] = 1'b0;
          srcOe[i] = 1'b0;
        end
        default: begin
          // analog input still drives digitally under direction
          if (route_q[i] && periphEn[i]) begin
            srcOut[i] = periphOut[i];
            srcOe[i] = periphOe[i] & ~dir_q[i];
          end else begin
            srcOut[i] = lat_q[i];
            srcOe[i] = ~dir_q[i];
          end
        end
      endcase
    end
  end

  // open drain drives only low
  assign padOut = srcOut & ~odr_q;
  assign padOe = srcOe & ~(odr_q & srcOut);

  // flag clear: write ones to the flag offset
  assign clrMask = wrHit(`GPIO_OFF_FLAG) ? regWdata[W-1:0] : '0;

  gpio_edge #(.W(W)) u_edge (
    .clk(clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .pinIn(digIn),
    .riseEn(rise_q),
    .fallEn(fall_q),
    .clrMask(clrMask),
    .flags(flags)
  );
  assign changeFlags = flags;

  // read mux, data stand one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (clkEn) begin
      if (regRd) begin
        case (regAddr)
          `GPIO_OFF_PIN: rdata_q <= ext(digIn);
          `GPIO_OFF_LAT: rdata_q <= ext(lat_q);
          `GPIO_OFF_DIR: rdata_q <= ext(dir_q);
          `GPIO_OFF_ANA: rdata_q <= ext(ana_q);
          `GPIO_OFF_PUP: rdata_q <= ext(pup_q);
          `GPIO_OFF_THR: rdata_q <= ext(thr_q);
          `GPIO_OFF_SLEW: rdata_q <= ext(slew_q);
          `GPIO_OFF_ODR: rdata_q <= ext(odr_q);
          `GPIO_OFF_RISE: rdata_q <= ext(rise_q);
          `GPIO_OFF_FALL: rdata_q <= ext(fall_q);
          `GPIO_OFF_FLAG: rdata_q <= ext(flags);
          `GPIO_OFF_ROUTE: rdata_q <= ext(route_q);
          default: rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign regRdata = rdata_q;

  // latch write lands in lat_q the next cycle
  // strobes written out here: a function body would read unsampled values
  property p_latch_drive;
    @(posedge clk) disable iff (!rst_b)
      (clkEn && regWr && regAddr == `GPIO_OFF_LAT)
      |=> (lat_q == $past(regWdata[W-1:0]));
  endproperty
  a_latch_drive: assert property (p_latch_drive) else $error("latch write lost");

  property p_pin_write;
    @(posedge clk) disable iff (!rst_b)
      (clkEn && regWr && regAddr == `GPIO_OFF_PIN) |=> (lat_q == $past(regWdata[W-1:0]));
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("pin write lost");

  property p_analog_zero;
    @(posedge clk) disable iff (!rst_b)
      (clkEn && regRd && regAddr == `GPIO_OFF_PIN)
      |=> ((regRdata[W-1:0] & $past(ana_q)) == '0);
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

  property p_lat_read;
    @(posedge clk) disable iff (!rst_b)
      (clkEn && regRd && regAddr == `GPIO_OFF_LAT && !regWr)
      |=> (regRdata == ext($past(lat_q)));
  endproperty
  a_lat_read: assert property (p_lat_read) else $error("latch read wrong");

  property p_aout_hiz;
    @(posedge clk) disable iff (!rst_b)
      (anaOutEn & ~cfgOwn) != '0 |-> ((padOe & anaOutEn & ~cfgOwn) == '0);
  endproperty
  a_aout_hiz: assert property (p_aout_hiz) else $error("driver on under analog out");

  property p_dir_input;
    @(posedge clk) disable iff (!rst_b)
      ((padOe & dir_q & ~cfgOwn) == '0);
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin driven");

  property p_open_drain;
    @(posedge clk) disable iff (!rst_b)
      ((padOe & padOut & odr_q) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_reset_state;
    @(posedge clk) (!rst_b) |=> (dir_q == `GPIO_RST_DIR && ana_q == `GPIO_RST_ANA
      && route_q == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset values wrong");

  property p_pullup;
    @(posedge clk) disable iff (!rst_b)
      (clkEn && regWr && regAddr == `GPIO_OFF_PUP) |=> (pullEn == $past(regWdata[W-1:0]));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not applied");
endmodule : gpio_port

// ### test/gpio_pin_model.sv
// Purpose: outside circuitry seen at the eight port pins
// Assumes: device drives a pin only while its enable is high
// Notes: an undriven pin follows the outside source level
`timescale 1ns/100ps
module gpio_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] padOut, // device driver value
  input wire logic [W-1:0] padOe, // device driver enable
  input wire logic [W-1:0] extDrv, // outside source level
  output logic [W-1:0] padIn // resolved pin level
);
  // device driver wins where enabled, else the outside source
  always_comb begin
    padIn = (padOe & padOut) | (~padOe & extDrv);
  end
endmodule : gpio_pin_model

// ### test/test_general_purpose_io_port.sv
// Purpose: self-checking bench of the port block
// Assumes: one clock, register port with read data one cycle later
// Notes: fixed seed; expectations from bench shadow state
`timescale 1ns/100ps
`include "gpio_map.svh"
module test_general_purpose_io_port
  import gpio_pkg::*;
;
  logic clk = 1'b0; // system clock
  logic rstB = 1'b0; // sync reset, active low
  logic clkEn = 1'b1; // run enable
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] cfgOwn = 8'h00, cfgOut = 8'h00, cfgOe = 8'h00, anaOutEn = 8'h00;
  logic [7:0] periphEn = 8'h00, periphOut = 8'h00, periphOe = 8'hff, extDrv = 8'h00;
  wire logic [7:0] regRdata, padIn, padOut, padOe, periphIn, pullEn, slewLimit;
  wire logic [7:0] ttlSel, i2cSlew, i2cPull, smbLevel, changeFlags;
  logic [7:0] lat = 8'h00, dir = 8'hff, ana = 8'hff, od = 8'h00, route = 8'h00;
  logic [7:0] oe, out, pin, v, eS, eP, eM; // expectations
  int numErrors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  gpio_port i_dut (.clk(clk), .rst_b(rstB), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .cfgOwn(cfgOwn), .cfgOut(cfgOut),
    .cfgOe(cfgOe), .anaOutEn(anaOutEn), .periphEn(periphEn), .periphOut(periphOut),
    .periphOe(periphOe), .periphIn(periphIn), .pullEn(pullEn), .slewLimit(slewLimit),
    .ttlSel(ttlSel), .i2cSlew(i2cSlew), .i2cPull(i2cPull), .smbLevel(smbLevel),
    .changeFlags(changeFlags));
  gpio_pin_model i_pins (.padOut(padOut), .padOe(padOe), .extDrv(extDrv), .padIn(padIn));
  // closing report and verdict
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      numErrors++;
      $display("BAD %0t run did not finish", $time);
      end_sim();
    end
  end
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data in the following cycle
  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rdChk
  // expected driver state from priorities
  function automatic void expPins(output logic [7:0] e, output logic [7:0] o);
    for (int i = 0; i < 8; i++) begin
      if (cfgOwn[i]) begin
        // open drain still masks a driven one on an overridden pin
        e[i] = cfgOe[i] && !(od[i] && cfgOut[i]);
        o[i] = cfgOut[i];
      end else if (anaOutEn[i]) begin
        e[i] = 1'b0;
        o[i] = lat[i];
      end else begin
        o[i] = (route[i] && periphEn[i]) ? periphOut[i] : lat[i];
        e[i] = !dir[i] && !(od[i] && o[i]) && !(route[i] && periphEn[i] && !periphOe[i]);
      end
    end
  endfunction : expPins
  // main sequence
  initial begin
    void'($urandom(32'hfdc823a9));
    repeat (12) @(posedge clk);
    rstB <= 1'b1;
    #1 chk(padOe, 8'h00);
    for (int a = 0; a < 16; a++) begin
      rdChk(4'(a), (a == 2 || a == 3) ? 8'hff : 8'h00);
    end
    $display("reset values done");
    // random port traffic with priority overrides
    for (int n = 0; n < 40; n++) begin
      lat = 8'($urandom);
      dir = 8'($urandom);
      ana = 8'($urandom);
      od = 8'($urandom);
      route = 8'($urandom);
      wr(n[0] ? `GPIO_OFF_PIN : `GPIO_OFF_LAT, lat);
      wr(`GPIO_OFF_DIR, dir);
      wr(`GPIO_OFF_ANA, ana);
      wr(`GPIO_OFF_ODR, od);
      wr(`GPIO_OFF_ROUTE, route);
      cfgOwn <= (n > 20) ? 8'($urandom) : 8'h00;
      cfgOut <= 8'($urandom);
      cfgOe <= 8'($urandom);
      anaOutEn <= (n > 10) ? 8'($urandom) : 8'h00;
      periphEn <= 8'($urandom);
      periphOut <= 8'($urandom);
      periphOe <= 8'($urandom);
      extDrv <= 8'($urandom);
      @(posedge clk);
      #1 expPins(oe, out);
      chk(padOe, oe);
      chk(padOut & oe, out & oe);
      pin = (oe & out) | (~oe & extDrv);
      chk(periphIn, pin & ~ana);
      rdChk(`GPIO_OFF_LAT, lat);
      rdChk(`GPIO_OFF_PIN, pin & ~ana);
    end
    // frozen clock enable blocks a write
    clkEn <= 1'b0;
    wr(`GPIO_OFF_LAT, ~lat);
    clkEn <= 1'b1;
    rdChk(`GPIO_OFF_LAT, lat);
    $display("port traffic done");
    // edge detection on digital inputs
    cfgOwn <= 8'h00;
    anaOutEn <= 8'h00;
    periphEn <= 8'h00;
    extDrv <= 8'h00;
    wr(`GPIO_OFF_DIR, 8'hff);
    wr(`GPIO_OFF_ANA, 8'h00);
    wr(`GPIO_OFF_RISE, 8'h01);
    wr(`GPIO_OFF_FALL, 8'h02);
    wr(`GPIO_OFF_FLAG, 8'hff);
    extDrv <= 8'h03;
    repeat (3) @(posedge clk);
    extDrv <= 8'h00;
    rdChk(`GPIO_OFF_FLAG, 8'h03);
    chk(changeFlags, 8'h03);
    // clear and fresh rising edge in one cycle: the edge wins
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= `GPIO_OFF_FLAG;
    regWdata <= 8'h01;
    extDrv <= 8'h01;
    @(posedge clk);
    regWr <= 1'b0;
    #1 chk(changeFlags, 8'h03);
    extDrv <= 8'h00;
    wr(`GPIO_OFF_FLAG, 8'h01);
    wr(`GPIO_OFF_ANA, 8'hff);
    extDrv <= 8'hff;
    repeat (3) @(posedge clk);
    rdChk(`GPIO_OFF_FLAG, 8'h02);
    $display("edge detection done");
    // pad controls; thresholds moved only with peripherals off
    periphEn <= 8'h00;
    for (int n = 0; n < 4; n++) begin
      v = 8'($urandom);
      wr(`GPIO_OFF_PUP, v);
      wr(`GPIO_OFF_THR, ~v);
      wr(`GPIO_OFF_SLEW, v ^ 8'h5a);
      #1 chk(pullEn, v);
      chk(ttlSel, ~v);
      chk(slewLimit, v ^ 8'h5a);
    end
    for (int p = 0; p < 8; p++) begin
      v = 8'($urandom);
      {eM[p], eP[p], eS[p]} = v[2:0];
      wr(`GPIO_OFF_I2C, {4'(p), 1'b0, v[2:0]});
    end
    #1 chk(i2cSlew, eS);
    chk(i2cPull, eP);
    chk(smbLevel, eM);
    rdChk(`GPIO_OFF_I2C, 8'h00);
    $display("pad controls done");
    end_sim();
  end
endmodule : test_general_purpose_io_port
